// >>> hw/idt_cfg.svh
`ifndef IDT_CFG_SVH
`define IDT_CFG_SVH

// ----------------------------------------
// Word layout
// ----------------------------------------
`define IDT_WORD_W 24
`define IDT_OPC_HI 23
`define IDT_OPC_LO 16
`define IDT_OPC_W 8
`define IDT_PAY_W 16
`define IDT_CLS_HI 7
`define IDT_CLS_LO 6
`define IDT_SUB_BIT 5
`define IDT_REG_W 4
`define IDT_MOD_W 2
`define IDT_FADR_W 13
`define IDT_SRC_LO 0
`define IDT_SMOD_LO 4
`define IDT_DST_LO 6
`define IDT_DMOD_LO 10
`define IDT_BASE_LO 12
`define IDT_TOW0_BIT 13
`define IDT_BPOS_LO 9
`define IDT_BYREG_BIT 14
`define IDT_BFILE_BIT 15
`define IDT_LIT5_LO 7
`define IDT_LIT5_W 5
`define IDT_LIT12_LO 4
`define IDT_LIT12_W 12
`define IDT_SEPD_BIT 6
`define IDT_TBL_LO 0

// ----------------------------------------
// Opcodes with special timing
// ----------------------------------------
`define IDT_OP_NOP 8'h00
`define IDT_OP_CALL_ABS 8'h02
`define IDT_OP_JUMP_ABS 8'h04
`define IDT_OP_LONG_LIT 8'h0a
`define IDT_OP_JREL 8'h10
`define IDT_OP_JREL_CMP 8'h11
`define IDT_OP_CALL_IND 8'h12
`define IDT_OP_JUMP_IND 8'h13
`define IDT_OP_TBL_RD 8'h14
`define IDT_OP_TBL_WR 8'h15
`define IDT_OP_RET 8'h16
`define IDT_OP_RETI 8'h17
`define IDT_OP_MOVD 8'h48
`define IDT_COND_MASK 8'hf0
`define IDT_COND_BASE 8'h20
`define IDT_SKIP_MASK 8'hf8
`define IDT_SKIP_BASE 8'h30
`define IDT_EXTRA_W 2
`define IDT_EXTRA_0 2'h0
`define IDT_EXTRA_1 2'h1
`define IDT_EXTRA_2 2'h2
`define IDT_MODE_DIRECT 2'h0
`endif

// >>> hw/idt_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "idt_cfg.svh"
module idt_decoder
	import idt_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic IW_VALID,
	input wire logic [`IDT_WORD_W-1:0] IW_WORD,
	output logic IW_READY,
	input wire logic COND_TRUE,
	output logic EXEC_VALID,
	output logic EXEC_NOP,
	output idt_fields_s EXEC_OP,
	output idt_we_s EXEC_WE,
	output logic SECOND_ERR
);
	// ----------------------------------------
	// Field decode of the word on the bus
	// ----------------------------------------
	idt_fields_s dec_f;
	idt_we_s dec_we;

	idt_field_dec u_dec (
		.word(IW_WORD),
		.fields(dec_f),
		.we(dec_we)
	);

	idt_state_e state_reg;
	idt_state_e state_next;
	idt_fields_s first_reg;
	idt_we_s first_we_reg;
	logic [`IDT_EXTRA_W-1:0] fill_reg;
	logic [`IDT_EXTRA_W-1:0] fill_next;

	// ----------------------------------------
	// Handshake and decisions
	// ----------------------------------------
	// Fetch stalls during filler cycles of the fill state so the next word is not lost
	wire st_run = (state_reg == IDT_ST_RUN);
	wire st_word2 = (state_reg == IDT_ST_WORD2);
	wire st_fill = (state_reg == IDT_ST_FILL);
	wire st_skip = (state_reg == IDT_ST_SKIP);
	wire st_skip2 = (state_reg == IDT_ST_SKIP2);
	assign IW_READY = !st_fill;
	wire take = IW_VALID && IW_READY;
	wire run_take = st_run && take;
	wire lone_second = run_take && (dec_f.opcode == `IDT_OP_NOP);
	wire start_two = run_take && dec_f.two_word;
	wire issue_one = run_take && !dec_f.two_word && !lone_second;
	wire issue_two = st_word2 && take;
	wire cond_hit = issue_one && dec_f.cond && COND_TRUE;
	wire skip_hit = issue_one && dec_f.skip && COND_TRUE;
	wire [`IDT_EXTRA_W-1:0] extra = cond_hit ? `IDT_EXTRA_1 : dec_f.extra;
	wire bad_top = issue_two &&
		(IW_WORD[`IDT_OPC_HI:`IDT_OPC_LO] != `IDT_OP_NOP);
	wire skip_word = (st_skip || st_skip2) && take;
	wire filler = st_fill || skip_word || lone_second;

	// Two-word result carries the second payload
	wire [`IDT_PAY_W-1:0] iw_payload = IW_WORD[`IDT_PAY_W-1:0];
	idt_fields_s merged;
	always_comb begin
		merged = first_reg;
		merged.ext_word = iw_payload;
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Next state and filler count
	always_comb begin
		state_next = state_reg;
		fill_next = fill_reg;
		case (state_reg)
			IDT_ST_RUN: begin
				if (start_two) begin
					state_next = IDT_ST_WORD2;
				end else if (skip_hit) begin
					state_next = IDT_ST_SKIP;
				end else if (issue_one && extra != `IDT_EXTRA_0) begin
					state_next = IDT_ST_FILL;
					fill_next = extra;
				end
			end
			IDT_ST_WORD2: begin
				if (take) begin
					state_next = IDT_ST_RUN;
				end
			end
			IDT_ST_FILL: begin
				fill_next = fill_reg - `IDT_EXTRA_1;
				if (fill_reg == `IDT_EXTRA_1) begin
					state_next = IDT_ST_RUN;
				end
			end
			IDT_ST_SKIP: begin
				if (take) begin
					// A skipped two-word costs one more cycle
					state_next = dec_f.two_word ? IDT_ST_SKIP2 : IDT_ST_RUN;
				end
			end
			IDT_ST_SKIP2: begin
				if (take) begin
					state_next = IDT_ST_RUN;
				end
			end
			default: begin
				state_next = IDT_ST_RUN;
			end
		endcase
	end

	// State, count and first-word hold
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg <= IDT_ST_RUN;
			fill_reg <= `IDT_EXTRA_0;
			first_reg <= '0;
			first_we_reg <= '0;
		end else begin
			state_reg <= state_next;
			fill_reg <= fill_next;
			if (start_two) begin
				first_reg <= dec_f;
				first_we_reg <= dec_we;
			end
		end
	end

	// ----------------------------------------
	// Execute outputs
	// ----------------------------------------
	// Filler cycles drop all write enables
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			EXEC_VALID <= 1'b0;
			EXEC_NOP <= 1'b0;
			EXEC_OP <= '0;
			EXEC_WE <= '0;
			SECOND_ERR <= 1'b0;
		end else begin
			EXEC_VALID <= issue_one || issue_two;
			EXEC_NOP <= filler;
			SECOND_ERR <= bad_top;
			if (issue_one) begin
				EXEC_OP <= dec_f;
				EXEC_WE <= dec_we;
			end else if (issue_two) begin
				EXEC_OP <= merged;
				EXEC_WE <= first_we_reg;
			end else begin
				EXEC_WE <= '0;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_two_first;
		run_take && dec_f.two_word;
	endsequence

	sequence s_two_second;
		IW_VALID && IW_READY;
	endsequence

	// Issue cycle of an instruction that owes filler, fetch held off
	sequence s_issue_hold;
		EXEC_VALID && !IW_READY;
	endsequence

	// Filler cycle with more filler still to come
	sequence s_fill_mid;
		EXEC_NOP && !IW_READY;
	endsequence

	// Last filler cycle; fetch is open again
	sequence s_fill_last;
		EXEC_NOP && IW_READY;
	endsequence

	property p_two_word_two_cycles;
		@(posedge CLK) disable iff (!RST_B)
			s_two_first ##1 s_two_second |=> EXEC_VALID && EXEC_OP.two_word;
	endproperty
	a_two_word_two_cycles: assert property (p_two_word_two_cycles)
		else $error("Two-word instruction not issued on its second word");

	property p_second_top_zero;
		@(posedge CLK) disable iff (!RST_B)
			(st_word2 && take && IW_WORD[`IDT_OPC_HI:`IDT_OPC_LO] != '0)
			|=> SECOND_ERR;
	endproperty
	a_second_top_zero: assert property (p_second_top_zero)
		else $error("Nonzero top byte in second word not flagged");

	property p_lone_second_nop;
		@(posedge CLK) disable iff (!RST_B)
			(run_take && IW_WORD[`IDT_OPC_HI:`IDT_OPC_LO] == '0)
			|=> EXEC_NOP && !EXEC_VALID;
	endproperty
	a_lone_second_nop: assert property (p_lone_second_nop)
		else $error("Lone second word did not act as nop");

	property p_cond_taken;
		@(posedge CLK) disable iff (!RST_B)
			(issue_one && dec_f.cond && COND_TRUE)
			|=> s_issue_hold ##1 s_fill_last;
	endproperty
	a_cond_taken: assert property (p_cond_taken)
		else $error("Taken condition did not add one filler cycle");

	property p_cond_not_taken;
		@(posedge CLK) disable iff (!RST_B)
			(issue_one && dec_f.cond && !COND_TRUE) |=> st_run;
	endproperty
	a_cond_not_taken: assert property (p_cond_not_taken)
		else $error("Untaken condition stalled");

	property p_return_three;
		@(posedge CLK) disable iff (!RST_B)
			(issue_one && (dec_f.opcode == `IDT_OP_RET ||
			dec_f.opcode == `IDT_OP_RETI))
			|=> s_issue_hold ##1 s_fill_mid ##1 s_fill_last;
	endproperty
	a_return_three: assert property (p_return_three)
		else $error("Return did not take three cycles");

	property p_skip_two_word;
		@(posedge CLK) disable iff (!RST_B)
			(st_skip && take && dec_f.two_word) |=> st_skip2;
	endproperty
	a_skip_two_word: assert property (p_skip_two_word)
		else $error("Skip over two-word instruction missed third cycle");

	property p_filler_quiet;
		@(posedge CLK) disable iff (!RST_B)
			EXEC_NOP |-> (EXEC_WE == '0) && !EXEC_VALID;
	endproperty
	a_filler_quiet: assert property (p_filler_quiet)
		else $error("Filler cycle carried a write enable");

	property p_class_from_opcode;
		@(posedge CLK) disable iff (!RST_B)
			EXEC_VALID |-> EXEC_OP.cls ==
				idt_class_e'(EXEC_OP.opcode[`IDT_CLS_HI:`IDT_CLS_LO]);
	endproperty
	a_class_from_opcode: assert property (p_class_from_opcode)
		else $error("Class does not follow opcode");

	// ----------------------------------------
	// Cycle counts and quiet filler
	// ----------------------------------------
	// Plain instruction issues once and leaves the fetch open
	property p_one_cycle;
		@(posedge CLK) disable iff (!RST_B)
			(issue_one && dec_f.extra == `IDT_EXTRA_0 && !dec_f.cond &&
			!dec_f.skip) |=> EXEC_VALID && IW_READY;
	endproperty
	a_one_cycle: assert property (p_one_cycle)
		else $error("Plain instruction did not finish in one cycle");

	// Branch, indirect and table ops owe exactly one filler cycle
	property p_pair_extra;
		@(posedge CLK) disable iff (!RST_B)
			(issue_one && dec_f.opcode >= `IDT_OP_JREL &&
			dec_f.opcode <= `IDT_OP_TBL_WR)
			|=> s_issue_hold ##1 s_fill_last;
	endproperty
	a_pair_extra: assert property (p_pair_extra)
		else $error("Branch or table op did not take two cycles");

	// Double-word move costs two cycles like the two-word ops
	property p_double_move;
		@(posedge CLK) disable iff (!RST_B)
			(issue_one && dec_f.opcode == `IDT_OP_MOVD)
			|=> s_issue_hold ##1 s_fill_last;
	endproperty
	a_double_move: assert property (p_double_move)
		else $error("Double-word move did not take two cycles");

	// Every filler cycle shows as a nop and never as an issue
	property p_fill_nop;
		@(posedge CLK) disable iff (!RST_B)
			st_fill |=> EXEC_NOP && !EXEC_VALID;
	endproperty
	a_fill_nop: assert property (p_fill_nop)
		else $error("Filler cycle not shown as a nop");

	// A skipped one-word instruction costs one nop, then fetch resumes
	property p_skip_one_word;
		@(posedge CLK) disable iff (!RST_B)
			(st_skip && take && !dec_f.two_word)
			|=> EXEC_NOP && !EXEC_VALID && st_run;
	endproperty
	a_skip_one_word: assert property (p_skip_one_word)
		else $error("Skip over one word took the wrong time");

	// The second word of a skipped pair is a nop as well
	property p_skip_second_nop;
		@(posedge CLK) disable iff (!RST_B)
			(st_skip2 && take) |=> EXEC_NOP && !EXEC_VALID && st_run;
	endproperty
	a_skip_second_nop: assert property (p_skip_second_nop)
		else $error("Second skipped word was not a nop");

	// A clean second word must not raise the error flag
	property p_second_clean;
		@(posedge CLK) disable iff (!RST_B)
			(st_word2 && take && IW_WORD[`IDT_OPC_HI:`IDT_OPC_LO] == '0)
			|=> !SECOND_ERR;
	endproperty
	a_second_clean: assert property (p_second_clean)
		else $error("Clean second word flagged as bad");

	// The first of two words issues nothing on its own
	property p_first_word_quiet;
		@(posedge CLK) disable iff (!RST_B)
			s_two_first |=> !EXEC_VALID && !EXEC_NOP;
	endproperty
	a_first_word_quiet: assert property (p_first_word_quiet)
		else $error("First word of a pair issued alone");

	// The second payload reaches the issued instruction unchanged
	property p_two_word_ext;
		@(posedge CLK) disable iff (!RST_B)
			s_two_first ##1 s_two_second
			|=> EXEC_OP.ext_word == $past(iw_payload);
	endproperty
	a_two_word_ext: assert property (p_two_word_ext)
		else $error("Second word payload lost");

	// Filler leaves the issued instruction untouched downstream
	property p_op_stable_fill;
		@(posedge CLK) disable iff (!RST_B)
			EXEC_NOP |-> $stable(EXEC_OP);
	endproperty
	a_op_stable_fill: assert property (p_op_stable_fill)
		else $error("Filler cycle changed the issued instruction");
endmodule // idt_decoder
`default_nettype wire

// >>> hw/idt_field_dec.sv
`timescale 1ns/100ps
`default_nettype none
`include "idt_cfg.svh"
module idt_field_dec
	import idt_pkg::*;
(
	input wire logic [`IDT_WORD_W-1:0] word,
	output idt_fields_s fields,
	output idt_we_s we
);
	// ----------------------------------------
	// Field slicing
	// ----------------------------------------
	wire [`IDT_OPC_W-1:0] opc = word[`IDT_OPC_HI:`IDT_OPC_LO];
	wire [`IDT_PAY_W-1:0] pay = word[`IDT_PAY_W-1:0];
	wire idt_class_e cls = idt_class_e'(opc[`IDT_CLS_HI:`IDT_CLS_LO]);
	wire sub = opc[`IDT_SUB_BIT];
	wire is_file = (cls == IDT_CLS_WORD) && sub;
	wire is_mov_lit = (cls == IDT_CLS_LIT) && sub;
	wire is_two = (opc == `IDT_OP_CALL_ABS) || (opc == `IDT_OP_JUMP_ABS) ||
		(opc == `IDT_OP_LONG_LIT);
	wire is_cond = (opc & `IDT_COND_MASK) == `IDT_COND_BASE;
	wire is_skip = (opc & `IDT_SKIP_MASK) == `IDT_SKIP_BASE;
	wire is_three = (opc == `IDT_OP_RET) || (opc == `IDT_OP_RETI);
	wire is_pair = (opc >= `IDT_OP_JREL && opc <= `IDT_OP_TBL_WR) ||
		(opc == `IDT_OP_MOVD);
	wire [`IDT_MOD_W-1:0] dmod = pay[`IDT_DMOD_LO+:`IDT_MOD_W];
	wire [`IDT_PAY_W-1:0] lit5 = {{(`IDT_PAY_W-`IDT_LIT5_W){1'b0}},
		pay[`IDT_LIT5_LO+:`IDT_LIT5_W]};
	wire [`IDT_PAY_W-1:0] lit12 = {{(`IDT_PAY_W-`IDT_LIT12_W){1'b0}},
		pay[`IDT_LIT12_LO+:`IDT_LIT12_W]};

	// Operand fields come from fixed positions; the class says which are live
	assign fields.opcode = opc;
	assign fields.cls = cls;
	assign fields.base_working_register = pay[`IDT_BASE_LO+:`IDT_REG_W];
	assign fields.source_working_register = pay[`IDT_SRC_LO+:`IDT_REG_W];
	assign fields.src_mode = pay[`IDT_SMOD_LO+:`IDT_MOD_W];
	assign fields.destination_working_register = pay[`IDT_DST_LO+:`IDT_REG_W];
	assign fields.dst_mode = dmod;
	assign fields.file_addr = pay[`IDT_FADR_W-1:0];
	assign fields.to_default_working_register = is_file &&
		pay[`IDT_TOW0_BIT];
	assign fields.bit_pos = pay[`IDT_BPOS_LO+:`IDT_REG_W];
	assign fields.bit_by_reg = pay[`IDT_BYREG_BIT];
	assign fields.bit_on_file = pay[`IDT_BFILE_BIT];
	assign fields.literal = is_mov_lit ? lit12 : lit5;
	assign fields.sep_dst = (cls == IDT_CLS_LIT) && !sub &&
		pay[`IDT_SEPD_BIT];
	assign fields.tbl_mode = pay[`IDT_TBL_LO+:`IDT_MOD_W];
	assign fields.ext_word = '0;
	assign fields.two_word = is_two;
	assign fields.cond = is_cond;
	assign fields.skip = is_skip;
	assign fields.extra = is_three ? `IDT_EXTRA_2 :
		(is_pair ? `IDT_EXTRA_1 : `IDT_EXTRA_0);

	// Write enables; a nop word writes nothing
	assign we.reg_we = (cls == IDT_CLS_WORD && !sub &&
		dmod == `IDT_MODE_DIRECT) || fields.to_default_working_register ||
		(cls == IDT_CLS_LIT && !pay[`IDT_BFILE_BIT]);
	assign we.mem_we = (is_file && !pay[`IDT_TOW0_BIT]) ||
		(cls == IDT_CLS_WORD && !sub && dmod != `IDT_MODE_DIRECT) ||
		(cls == IDT_CLS_BIT) || (is_mov_lit && pay[`IDT_BFILE_BIT]);
	assign we.flag_we = (cls == IDT_CLS_WORD) || (cls == IDT_CLS_BIT) ||
		(cls == IDT_CLS_LIT && !sub);
endmodule // idt_field_dec
`default_nettype wire

// >>> hw/idt_pkg.sv
`default_nettype none
`include "idt_cfg.svh"
package idt_pkg;
	typedef enum logic [1:0] {
		IDT_CLS_CTRL = 2'h0,
		IDT_CLS_WORD = 2'h1,
		IDT_CLS_LIT = 2'h2,
		IDT_CLS_BIT = 2'h3
	} idt_class_e;

	typedef enum logic [4:0] {
		IDT_ST_RUN = 5'h01,
		IDT_ST_WORD2 = 5'h02,
		IDT_ST_FILL = 5'h04,
		IDT_ST_SKIP = 5'h08,
		IDT_ST_SKIP2 = 5'h10
	} idt_state_e;

	typedef struct packed {
		logic [`IDT_OPC_W-1:0] opcode;
		idt_class_e cls;
		logic [`IDT_REG_W-1:0] base_working_register;
		logic [`IDT_REG_W-1:0] source_working_register;
		logic [`IDT_MOD_W-1:0] src_mode;
		logic [`IDT_REG_W-1:0] destination_working_register;
		logic [`IDT_MOD_W-1:0] dst_mode;
		logic [`IDT_FADR_W-1:0] file_addr;
		logic to_default_working_register;
		logic [`IDT_REG_W-1:0] bit_pos;
		logic bit_by_reg;
		logic bit_on_file;
		logic [`IDT_PAY_W-1:0] literal;
		logic sep_dst;
		logic [`IDT_MOD_W-1:0] tbl_mode;
		logic [`IDT_PAY_W-1:0] ext_word;
		logic two_word;
		logic cond;
		logic skip;
		logic [`IDT_EXTRA_W-1:0] extra;
	} idt_fields_s;

	typedef struct packed {
		logic reg_we;
		logic mem_we;
		logic flag_we;
	} idt_we_s;
endpackage
`default_nettype wire

// >>> testbench/idt_prog_mem.sv
`timescale 1ns/100ps
`default_nettype none
`include "idt_cfg.svh"
// ----------------------------------------
// Program memory model
// ----------------------------------------
module idt_prog_mem
	import idt_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic IW_READY,
	output logic IW_VALID,
	output logic [`IDT_WORD_W-1:0] IW_WORD
);
	logic [`IDT_WORD_W-1:0] q [$];
	int gap = 0;
	int cnt = 0;
	// Holds a word until taken; idle data toggles so stale words look bad
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			IW_VALID <= 1'b0;
			IW_WORD <= 24'h000000;
			cnt = 0;
		end else begin
			if (IW_VALID && IW_READY) begin
				q.delete(0);
				cnt = gap;
			end
			if (cnt > 0 || q.size() == 0) begin
				cnt = (cnt > 0) ? cnt - 1 : 0;
				IW_VALID <= 1'b0;
				IW_WORD <= ~IW_WORD;
			end else begin
				IW_VALID <= 1'b1;
				IW_WORD <= q[0];
			end
		end
	end
	// Queues one word for delivery
	task automatic push(input logic [`IDT_WORD_W-1:0] w);
		q.push_back(w);
	endtask
endmodule // idt_prog_mem
`default_nettype wire

// >>> testbench/tb_instruction_decode_timing.sv
`timescale 1ns/100ps
`default_nettype none
`include "idt_cfg.svh"
module tb_instruction_decode_timing
	import idt_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b;
	logic cond_true = 1'b0;
	logic iw_valid, iw_ready, exec_valid, exec_nop, second_err;
	logic [`IDT_WORD_W-1:0] iw_word;
	idt_fields_s exec_op;
	idt_we_s exec_we;
	int fails = 0;
	int n_compared = 0;
	logic [15:0] vt, nt, et, wt;
	logic [7:0] ops [9] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h48,
		8'h02, 8'h04};

	// ----------------------------------------
	// Clock, design and memory
	// ----------------------------------------
	// Half period of 2 ns gives 250 MHz
	always #2 clk = ~clk;

	idt_decoder i_dut (.CLK(clk), .RST_B(rst_b), .IW_VALID(iw_valid),
		.IW_WORD(iw_word), .IW_READY(iw_ready), .COND_TRUE(cond_true),
		.EXEC_VALID(exec_valid), .EXEC_NOP(exec_nop), .EXEC_OP(exec_op),
		.EXEC_WE(exec_we), .SECOND_ERR(second_err));

	idt_prog_mem i_mem (.CLK(clk), .RST_B(rst_b), .IW_READY(iw_ready),
		.IW_VALID(iw_valid), .IW_WORD(iw_word));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Queues words, then traces sixteen cycles; bit k is after edge k+1
	task automatic go(input logic [95:0] ws, input int nw, input logic c);
		@(posedge clk);
		cond_true <= c;
		#1;
		for (int i = 0; i < nw; i++) i_mem.push(ws[95-24*i -: 24]);
		for (int k = 0; k < 16; k++) begin
			@(posedge clk);
			#1;
			vt[k] = exec_valid;
			nt[k] = exec_nop;
			et[k] = second_err;
			wt[k] = exec_nop & (|exec_we);
		end
	endtask

	task automatic end_sim;
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		chk({iw_ready, exec_valid, exec_nop, second_err}, 4'h8);
		chk({|exec_op, |exec_we}, 2'h0);
	endtask

	// Back-to-back register ops, one cycle each, operand split
	task automatic t_single;
		go({24'h40a563, 24'h40a563, 48'h0}, 2, 1'b0);
		chk({nt, vt}, 32'h00000006);
		chk({exec_op.opcode, exec_op.cls}, {8'h40, IDT_CLS_WORD});
		chk({exec_op.base_working_register, exec_op.source_working_register,
			exec_op.src_mode, exec_op.destination_working_register,
			exec_op.dst_mode}, {4'ha, 4'h3, 2'h2, 4'h5, 2'h1});
	endtask

	// Opcodes with one extra filler cycle, including the double move
	task automatic t_extra1;
		for (int i = 0; i < 7; i++) begin
			go({ops[i], 16'h0003, 72'h0}, 1, 1'b0);
			chk({nt, vt}, 32'h00040002);
			if (ops[i] == 8'h14) chk(exec_op.tbl_mode, 2'h3);
		end
		go({24'h140003, 72'h0}, 1, 1'b0);
		chk(exec_op.cls, IDT_CLS_CTRL);
	endtask

	// Returns hold off the next word for two filler cycles
	task automatic t_return;
		for (int op = 8'h16; op <= 8'h17; op++) begin
			go({op[7:0], 16'h0000, 24'h40a563, 48'h0}, 2, 1'b0);
			chk({nt, vt}, 32'h000c0012);
			chk(wt, 16'h0000);
		end
	endtask

	task automatic t_cond;
		go({24'h2f0000, 72'h0}, 1, 1'b1);
		chk({nt, vt}, 32'h00040002);
		go({24'h200000, 72'h0}, 1, 1'b0);
		chk({nt, vt}, 32'h00000002);
	endtask

	// The three two-word instructions and a malformed second word
	task automatic t_two;
		for (int i = 0; i < 3; i++) begin
			go({(i == 2) ? 8'h0a : ops[7 + i], 16'h0000, 24'h00abcd, 48'h0},
				2, 1'b0);
			chk({nt, vt}, 32'h00000004);
			chk({exec_op.two_word, exec_op.ext_word}, 17'h1abcd);
			chk(et, 16'h0000);
		end
		go({24'h040000, 24'h05abcd, 48'h0}, 2, 1'b0);
		chk({et, vt}, 32'h00040004);
		go({24'h001234, 72'h0}, 1, 1'b0);
		chk({nt, vt}, 32'h00020000);
	endtask

	// Skips over one word, over two words, and not taken
	task automatic t_skip;
		go({24'h300000, 24'h400000, 24'h40a563, 24'h0}, 3, 1'b1);
		chk({nt, vt}, 32'h0004000a);
		chk(wt, 16'h0000);
		go({24'h370000, 24'h020000, 24'h000000, 24'h40a563}, 4, 1'b1);
		chk({nt, vt}, 32'h000c0012);
		chk(wt, 16'h0000);
		go({24'h300000, 24'h400000, 48'h0}, 2, 1'b0);
		chk({nt, vt}, 32'h00000006);
	endtask

	task automatic t_fields;
		go({24'h603234, 72'h0}, 1, 1'b0);
		chk({exec_op.file_addr, exec_op.to_default_working_register},
			{13'h1234, 1'b1});
		go({24'hc05200, 72'h0}, 1, 1'b0);
		chk({exec_op.cls, exec_op.bit_pos, exec_op.bit_by_reg,
			exec_op.bit_on_file}, {IDT_CLS_BIT, 4'h9, 2'h2});
		go({24'h800040, 72'h0}, 1, 1'b0);
		chk({exec_op.cls, exec_op.sep_dst}, {IDT_CLS_LIT, 1'b1});
		go({24'ha0abc0, 72'h0}, 1, 1'b0);
		chk({exec_op.cls, exec_op.literal}, {IDT_CLS_LIT, 16'h0abc});
	endtask

	// Memory pauses two cycles between words
	task automatic t_slow;
		i_mem.gap = 2;
		go({24'h40a563, 24'h40a563, 48'h0}, 2, 1'b0);
		chk({nt, vt}, 32'h00000012);
		i_mem.gap = 0;
	endtask

	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	// Main sequence
	initial begin
		rst_b = 1'b0;
		repeat (20) @(posedge clk);
		t_reset;
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		t_single;
		t_extra1;
		t_return;
		t_cond;
		t_two;
		t_skip;
		t_fields;
		t_slow;
		end_sim;
	end

	// About 465 cycles are needed, so 3000 means a hang
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		end_sim;
	end
endmodule // tb_instruction_decode_timing
`default_nettype wire
